// ===== debi_ext_mem.sv
// debi_ext_mem: external memory and host seen from the bus pins.
// assumes: device pins split into out/oe; the wire levels are resolved here.
`timescale 1ns/1ps
`default_nettype none
module debi_ext_mem (
  input wire logic sys_clk,
  input wire logic memSel,
  input wire logic hostMode,
  input wire logic [15:0] hostA,
  input wire logic [15:0] hostD,
  input wire logic [22:0] addrOut,
  input wire logic [22:0] addrOe,
  input wire logic [15:0] dataOut,
  input wire logic [15:0] dataOe,
  output logic [22:0] addrIn,
  output logic [15:0] dataIn
);
  logic [15:0] mem [0:255];
  // ********************
  // pin resolution
  // ********************
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'(i * 16'h0101);
    end
  end
  always_comb begin
    addrIn = addrOut;
    if (hostMode) begin
      addrIn[15:0] = hostA;
    end
    // unselected memory leaves the wire to the device holder
    if (dataOe != 16'h0000) begin
      dataIn = dataOut;
    end else if (hostMode) begin
      dataIn = hostD;
    end else if (memSel && addrOe == 23'h7f_ffff) begin
      dataIn = mem[addrOut[7:0]];
    end else begin
      dataIn = dataOut;
    end
  end
  always @(posedge sys_clk) begin
    if (dataOe == 16'hffff) begin
      mem[addrOut[7:0]] <= dataOut;
    end
  end
endmodule
`default_nettype wire

// ===== debi_irq_ctrl.sv
// debi_irq_ctrl: interrupt flag register, masking, priority and vector pick.
// assumes: irq lines are active low and synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module debi_irq_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [debi_pkg::NUM_IRQ-1:0] userIrqN,
  input wire logic nmiN,
  input wire logic [debi_pkg::NUM_IRQ-1:0] irqMask,
  input wire logic globalIrqDisable,
  input wire logic [debi_pkg::NUM_IRQ-1:0] flagClear,
  input wire logic takeAck,
  output logic [debi_pkg::NUM_IRQ-1:0] irqFlags,
  output logic irqRequest,
  output logic [15:0] irqVector
);
  import debi_pkg::*;
  logic [NUM_IRQ-1:0] prevIrqN;
  logic prevNmiN;
  logic nmiPend;
  logic [NUM_IRQ-1:0] next_irqFlags;
  logic next_nmiPend;
  logic [NUM_IRQ-1:0] fallEdge;
  logic [NUM_IRQ-1:0] eligible;
  logic [1:0] winner;

  always_comb begin
    fallEdge = prevIrqN & ~userIrqN;
    eligible = irqFlags & irqMask & {NUM_IRQ{~globalIrqDisable}};
    winner = 2'd0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        winner = 2'(i);
      end
    end
    irqRequest = nmiPend | (|eligible);
    irqVector = nmiPend ? NMI_VECTOR : (IRQ_VECTOR_BASE + {12'h000, winner, 2'b00});
    next_nmiPend = nmiPend;
    if (takeAck && nmiPend) begin
      next_nmiPend = 1'b0;
    end
    if (prevNmiN && !nmiN) begin
      next_nmiPend = 1'b1;
    end
    // set wins over a clear landing in the same cycle
    next_irqFlags = irqFlags & ~flagClear;
    if (takeAck && !nmiPend && (|eligible)) begin
      next_irqFlags[winner] = 1'b0;
    end
    next_irqFlags = next_irqFlags | fallEdge;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqFlags <= IFR_RESET;
      nmiPend <= 1'b0;
      prevIrqN <= '1;
      prevNmiN <= 1'b1;
    end else begin
      irqFlags <= next_irqFlags;
      nmiPend <= next_nmiPend;
      prevIrqN <= userIrqN;
      prevNmiN <= nmiN;
    end
  end

  a_flag_set_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (prevIrqN[0] && !userIrqN[0]) |=> irqFlags[0])
    else $error("falling irq edge did not set flag");
  a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!nmiPend && globalIrqDisable) |-> !irqRequest)
    else $error("request while globally disabled");
  a_nmi_unmasked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (prevNmiN && !nmiN) |=> irqRequest && irqVector == NMI_VECTOR)
    else $error("nmi not raised");
endmodule
`default_nettype wire

// ===== debi_pkg.sv
// debi_pkg: constants shared by the external bus / interrupt / reset pin block.
// assumes: included before debi_irq_ctrl.sv and debi_top.sv.
package debi_pkg;
  localparam int ADDR_W = 23;
  localparam int LOW_ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_IRQ = 4;
  localparam logic [22:0] RESET_VECTOR = 23'h00_FF80;
  localparam logic [15:0] NMI_VECTOR = 16'hFF88;
  localparam logic [15:0] IRQ_VECTOR_BASE = 16'hFFC0;
  localparam logic [3:0] IMR_RESET = 4'h0;
  localparam logic [3:0] IFR_RESET = 4'h0;
  localparam logic HOLDER_EN_RESET = 1'b1;
  localparam logic GLOBAL_DIS_RESET = 1'b1;
  localparam int VEC_FETCH_CYCLES = 2;
endpackage

// ===== debi_top.sv
// debi_top: pin-level external address/data bus, interrupt ack and reset sequencing.
// assumes: the core supplies bus requests; pins split into in/out/enable,
// the board resolves the wires. all inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module debi_top #(
  parameter int ADDR_WIDTH = debi_pkg::ADDR_W,
  parameter int DATA_WIDTH = debi_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic resetPinN,
  input wire logic holdRequestN,
  input wire logic outputFloatN,
  input wire logic wideHostPortModeSelect,
  input wire logic [debi_pkg::NUM_IRQ-1:0] externalUserIrqLinesN,
  input wire logic nmiN,
  input wire logic [ADDR_WIDTH-1:0] externalAddressLinesIn,
  output logic [ADDR_WIDTH-1:0] externalAddressLinesOut,
  output logic [ADDR_WIDTH-1:0] externalAddressLinesOe,
  input wire logic [DATA_WIDTH-1:0] externalDataLinesIn,
  output logic [DATA_WIDTH-1:0] externalDataLinesOut,
  output logic [DATA_WIDTH-1:0] externalDataLinesOe,
  output logic interruptAckOutputN,
  output logic interruptAckOe,
  input wire logic coreReq,
  input wire logic coreWrite,
  input wire logic coreProgSpace,
  input wire logic [ADDR_WIDTH-1:0] coreAddr,
  input wire logic [DATA_WIDTH-1:0] coreWrData,
  output logic [DATA_WIDTH-1:0] coreRdData,
  input wire logic [debi_pkg::NUM_IRQ-1:0] irqMaskRegister,
  input wire logic globalIrqDisableBit,
  input wire logic [debi_pkg::NUM_IRQ-1:0] irqFlagClear,
  output logic [debi_pkg::NUM_IRQ-1:0] irqFlagRegister,
  input wire logic bankSwitchHolderEnWe,
  input wire logic bankSwitchHolderEnData,
  output logic dataHolderEnable,
  output logic [ADDR_WIDTH-1:0] programCounter,
  output logic coreRunning,
  output logic [debi_pkg::LOW_ADDR_W-1:0] hostAddr,
  output logic [DATA_WIDTH-1:0] hostData
);
  import debi_pkg::*;
  localparam int LOW_ADDR_W_T = LOW_ADDR_W;

  if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W) begin
    $error("bus widths fixed by pin map");
  end
  // ack counter is only two bits wide
  if (VEC_FETCH_CYCLES < 1 || VEC_FETCH_CYCLES > 4) begin
    $error("vector fetch length out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_ACK   = 4'b0100,
    ST_HOLD  = 4'b1000
  } debi_state_e;

  debi_state_e state, next_state;
  logic [ADDR_WIDTH-1:0] next_programCounter;
  logic [ADDR_WIDTH-1:0] addrOut, next_addrOut;
  logic [DATA_WIDTH-1:0] dataOut, next_dataOut;
  logic driveData, next_driveData;
  logic driveAddr, next_driveAddr;
  logic ackActive, next_ackActive;
  logic [1:0] ackCnt, next_ackCnt;
  logic next_dataHolderEnable;
  logic [DATA_WIDTH-1:0] next_coreRdData;
  logic [LOW_ADDR_W_T-1:0] next_hostAddr;
  logic [DATA_WIDTH-1:0] next_hostData;
  logic irqRequest;
  logic [15:0] irqVector;
  logic takeAck;

  debi_irq_ctrl u_irq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .userIrqN(externalUserIrqLinesN),
    .nmiN(nmiN),
    .irqMask(irqMaskRegister),
    .globalIrqDisable(globalIrqDisableBit),
    .flagClear(irqFlagClear),
    .takeAck(takeAck),
    .irqFlags(irqFlagRegister),
    .irqRequest(irqRequest),
    .irqVector(irqVector)
  );

  assign takeAck = (state == ST_RUN) && irqRequest && resetPinN && holdRequestN;

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    next_programCounter = programCounter;
    next_addrOut = addrOut;
    next_dataOut = dataOut;
    next_driveData = 1'b0;
    next_driveAddr = driveAddr;
    next_ackActive = 1'b0;
    next_ackCnt = ackCnt;
    next_coreRdData = coreRdData;
    next_hostAddr = hostAddr;
    next_hostData = hostData;
    next_dataHolderEnable = dataHolderEnable;
    if (bankSwitchHolderEnWe) begin
      next_dataHolderEnable = bankSwitchHolderEnData;
    end
    if (wideHostPortModeSelect) begin
      next_hostAddr = externalAddressLinesIn[LOW_ADDR_W_T-1:0];
      next_hostData = externalDataLinesIn;
    end
    if (!resetPinN) begin
      next_state = ST_RESET;
      next_programCounter = RESET_VECTOR;
      next_driveAddr = 1'b0;
    end else begin
      unique case (state)
        ST_RESET: begin
          next_state = ST_RUN;
          next_addrOut = RESET_VECTOR;
          next_driveAddr = 1'b1;
        end
        ST_RUN: begin
          if (!holdRequestN) begin
            next_state = ST_HOLD;
            next_driveAddr = 1'b0;
          end else if (takeAck) begin
            next_state = ST_ACK;
            next_ackActive = 1'b1;
            next_ackCnt = 2'(VEC_FETCH_CYCLES - 1);
            next_addrOut = {addrOut[ADDR_WIDTH-1:LOW_ADDR_W_T], irqVector};
            next_programCounter = {7'h00, irqVector};
            next_driveAddr = 1'b1;
          end else if (coreReq) begin
            // upper lines only change for program space accesses
            if (coreProgSpace) begin
              next_addrOut = coreAddr;
            end else begin
              next_addrOut[LOW_ADDR_W_T-1:0] = coreAddr[LOW_ADDR_W_T-1:0];
            end
            next_driveAddr = 1'b1;
            if (coreWrite) begin
              next_dataOut = coreWrData;
              next_driveData = 1'b1;
            end else begin
              next_coreRdData = externalDataLinesIn;
            end
            next_programCounter = programCounter + 23'h00_0001;
          end
        end
        ST_ACK: begin
          next_ackActive = 1'b1;
          if (ackCnt == 2'd0) begin
            next_ackActive = 1'b0;
            next_state = ST_RUN;
          end else begin
            next_ackCnt = ackCnt - 2'd1;
          end
        end
        ST_HOLD: begin
          next_driveAddr = 1'b0;
          if (holdRequestN) begin
            next_state = ST_RUN;
            next_driveAddr = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RESET;
      programCounter <= RESET_VECTOR;
      addrOut <= '0;
      dataOut <= '0;
      driveData <= 1'b0;
      driveAddr <= 1'b0;
      ackActive <= 1'b0;
      ackCnt <= 2'd0;
      coreRdData <= '0;
      hostAddr <= '0;
      hostData <= '0;
      dataHolderEnable <= HOLDER_EN_RESET;
    end else begin
      state <= next_state;
      programCounter <= next_programCounter;
      addrOut <= next_addrOut;
      dataOut <= next_dataOut;
      driveData <= next_driveData;
      driveAddr <= next_driveAddr;
      ackActive <= next_ackActive;
      ackCnt <= next_ackCnt;
      coreRdData <= next_coreRdData;
      hostAddr <= next_hostAddr;
      hostData <= next_hostData;
      dataHolderEnable <= next_dataHolderEnable;
    end
  end

  // ****************************************
  // pin drivers and bus holders
  // ****************************************
  // holders modelled as weak keeper drive of the last value; the board
  // resolves strong drive from others over it.
  logic addrFloat;
  logic dataFloat;
  logic [ADDR_WIDTH-1:0] addrHeld, next_addrHeld;
  logic [DATA_WIDTH-1:0] dataHeld, next_dataHeld;
  always_comb begin
    addrFloat = !driveAddr || !outputFloatN || !holdRequestN || state == ST_HOLD;
    dataFloat = !driveData || !resetPinN || !holdRequestN || !outputFloatN;
    // keeper copies track the driven value and freeze while addrFloat/dataFloat are set, not when only host mode floats the pins
    next_addrHeld = addrFloat ? addrHeld : addrOut;
    next_dataHeld = dataFloat ? dataHeld : dataOut;
    externalAddressLinesOut = addrFloat ? addrHeld : addrOut;
    externalAddressLinesOe = addrFloat ? '0 : '1;
    if (wideHostPortModeSelect) begin
      externalAddressLinesOe[LOW_ADDR_W_T-1:0] = '0;
    end
    externalDataLinesOut = dataFloat ? dataHeld : dataOut;
    externalDataLinesOe = (dataFloat || wideHostPortModeSelect) ? '0 : '1;
    interruptAckOutputN = !ackActive;
    interruptAckOe = outputFloatN;
    coreRunning = (state != ST_RESET) && resetPinN;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrHeld <= '0;
      dataHeld <= '0;
    end else begin
      addrHeld <= next_addrHeld;
      dataHeld <= next_dataHeld;
    end
  end

  a_float_ctrl: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !outputFloatN |-> (externalAddressLinesOe == '0) && (externalDataLinesOe == '0)
      && !interruptAckOe)
    else $error("bus driven while float control low");
  a_hold_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !holdRequestN |-> externalAddressLinesOe == '0 && externalDataLinesOe == '0)
    else $error("bus driven during hold");
  a_reset_pc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !resetPinN |=> programCounter == RESET_VECTOR && !coreRunning)
    else $error("reset did not force pc");
  a_reset_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!resetPinN ##1 resetPinN && holdRequestN) |=> addrOut == RESET_VECTOR)
    else $error("first fetch not at reset address");
  a_ack_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
    takeAck && holdRequestN |=> !interruptAckOutputN[*2])
    else $error("ack not held for vector fetch");
  a_wide_host_in: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wideHostPortModeSelect |-> externalAddressLinesOe[15:0] == '0)
    else $error("low address driven in host mode");
  a_holder_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (externalDataLinesOe == '0 && !bankSwitchHolderEnWe) |=>
      externalDataLinesOut == $past(externalDataLinesOut) || driveData)
    else $error("data holder lost level");
  a_holder_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bankSwitchHolderEnWe |=> dataHolderEnable == $past(bankSwitchHolderEnData))
    else $error("holder enable not written");
  a_addr_holder: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!addrFloat ##1 addrFloat) |-> externalAddressLinesOut == $past(addrOut))
    else $error("address holder lost level");
  a_data_rst_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !resetPinN |-> externalDataLinesOe == '0)
    else $error("data driven during reset");
  a_host_data_in: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wideHostPortModeSelect |-> externalDataLinesOe == '0)
    else $error("data driven in host mode");
  a_upper_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_RUN && coreReq && !coreProgSpace) |=> $stable(addrOut[ADDR_WIDTH-1:LOW_ADDR_W_T]))
    else $error("upper lines moved on data access");
endmodule
`default_nettype wire

// ===== tb_dsp_external_bus_irq_reset_pins.sv
// tb_dsp_external_bus_irq_reset_pins: self-checking bench for debi_top.
// assumes: debi_pkg, debi_irq_ctrl, debi_top and debi_ext_mem compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_dsp_external_bus_irq_reset_pins;
  import debi_pkg::*;
  logic sys_clk, rst_n, resetPinN, holdRequestN, outputFloatN, hostMode, nmiN, globalDis;
  logic coreReq, coreWrite, coreProg, holdWe, holdD, holdEn, ackN, ackOe, running, memSel;
  logic [3:0] irqN, irqMask, flagClr, flags;
  logic [22:0] aIn, aOut, aOe, coreAddr, pc, expA, a;
  logic [15:0] dIn, dOut, dOe, wrData, rdData, hAddr, hData, hostA, hostD, d;
  int n_errors = 0;
  int cmp_count = 0;
  int q[$];
  debi_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .resetPinN(resetPinN),
    .holdRequestN(holdRequestN), .outputFloatN(outputFloatN),
    .wideHostPortModeSelect(hostMode), .externalUserIrqLinesN(irqN), .nmiN(nmiN),
    .externalAddressLinesIn(aIn), .externalAddressLinesOut(aOut), .externalAddressLinesOe(aOe),
    .externalDataLinesIn(dIn), .externalDataLinesOut(dOut), .externalDataLinesOe(dOe),
    .interruptAckOutputN(ackN), .interruptAckOe(ackOe), .coreReq(coreReq),
    .coreWrite(coreWrite), .coreProgSpace(coreProg), .coreAddr(coreAddr),
    .coreWrData(wrData), .coreRdData(rdData), .irqMaskRegister(irqMask),
    .globalIrqDisableBit(globalDis), .irqFlagClear(flagClr), .irqFlagRegister(flags),
    .bankSwitchHolderEnWe(holdWe), .bankSwitchHolderEnData(holdD),
    .dataHolderEnable(holdEn), .programCounter(pc), .coreRunning(running),
    .hostAddr(hAddr), .hostData(hData));
  debi_ext_mem ext (.sys_clk(sys_clk), .memSel(memSel), .hostMode(hostMode), .hostA(hostA),
    .hostD(hostD), .addrOut(aOut), .addrOe(aOe), .dataOut(dOut), .dataOe(dOe),
    .addrIn(aIn), .dataIn(dIn));
  // ********************
  // shared tasks
  // ********************
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic access(input logic w, input logic p, input logic [22:0] ad,
                        input logic [15:0] dt);
    coreWrite = w;
    coreProg = p;
    coreAddr = ad;
    wrData = dt;
    coreReq = 1'b1;
    tick();
    coreReq = 1'b0;
    // data space moves only the shared low lines
    if (holdRequestN) begin
      expA = p ? ad : {expA[22:16], ad[15:0]};
    end
  endtask
  task automatic pinReset();
    resetPinN = 1'b0;
    tick();
    tick();
    `CHK(running, 1'b0)
    `CHK(pc, RESET_VECTOR)
    `CHK(dOe, 16'h0000)
    resetPinN = 1'b1;
    tick();
    `CHK(running, 1'b1)
    `CHK(aOut, RESET_VECTOR)
    `CHK(aOe, 23'h7f_ffff)
    `CHK(ackOe, 1'b1)
    expA = RESET_VECTOR;
  endtask
  task automatic pulse(input logic [3:0] lines);
    irqN = lines;
    tick();
    irqN = 4'hf;
  endtask
  task automatic waitAck(input logic [15:0] vec);
    int k;
    k = 0;
    while (ackN !== 1'b0 && k < 20) begin
      tick();
      k++;
    end
    `CHK(k < 20, 1'b1)
    `CHK(aOut[15:0], vec)
    tick();
    `CHK(ackN, 1'b0)
    tick();
    `CHK(ackN, 1'b1)
  endtask
  // ********************
  // tests
  // ********************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #25000;
    n_errors++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    resetPinN = 1'b0;
    holdRequestN = 1'b1;
    nmiN = 1'b1;
    irqN = 4'hf;
    outputFloatN = 1'b1;
    {hostMode, globalDis, coreReq, coreWrite, coreProg, holdWe, holdD, memSel} = 8'h00;
    {irqMask, flagClr, coreAddr, wrData, hostA, hostD} = '0;
    void'($urandom(32'h9c8d_7302));
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    `CHK(holdEn, HOLDER_EN_RESET)
    `CHK(flags, IFR_RESET)
    pinReset();
    for (int i = 0; i < 6; i++) begin
      a = 23'($urandom);
      d = 16'($urandom);
      access(1'b1, i[0], a, d);
      `CHK(aOut, expA)
      `CHK(aOe, 23'h7f_ffff)
      `CHK(dOut, d)
      `CHK(dOe, 16'hffff)
      tick();
      `CHK(dOe, 16'h0000)
      `CHK(dOut, d)
      memSel = 1'b1;
      access(1'b0, i[0], a, 16'h0000);
      tick();
      `CHK(rdData, d)
      memSel = 1'b0;
    end
    holdRequestN = 1'b0;
    tick();
    access(1'b1, 1'b1, 23'h12_3456, 16'h5a5a);
    tick();
    `CHK(aOe, 23'h00_0000)
    `CHK(dOe, 16'h0000)
    `CHK(aOut, expA)
    holdRequestN = 1'b1;
    outputFloatN = 1'b0;
    tick();
    tick();
    `CHK(aOe, 23'h00_0000)
    `CHK(dOe, 16'h0000)
    `CHK(ackOe, 1'b0)
    outputFloatN = 1'b1;
    hostMode = 1'b1;
    hostA = 16'($urandom);
    hostD = 16'($urandom);
    tick();
    tick();
    `CHK(aOe[15:0], 16'h0000)
    `CHK(hAddr, hostA)
    `CHK(hData, hostD)
    hostMode = 1'b0;
    for (int v = 0; v < 2; v++) begin
      holdD = v[0];
      holdWe = 1'b1;
      tick();
      holdWe = 1'b0;
      tick();
      `CHK(holdEn, v[0])
    end
    irqMask = 4'hf;
    for (int n = 0; n < 4; n++) begin
      pulse(4'hf ^ (4'h1 << n));
      waitAck(IRQ_VECTOR_BASE + 16'(4 * n));
      tick();
      `CHK(flags, 4'h0)
    end
    q = {3, 0};
    pulse(4'h6);
    while (q.size() > 0) waitAck(IRQ_VECTOR_BASE + 16'(4 * q.pop_back()));
    irqMask = 4'hd;
    pulse(4'hd);
    repeat (4) tick();
    `CHK(ackN, 1'b1)
    `CHK(flags, 4'h2)
    flagClr = 4'h2;
    tick();
    flagClr = 4'h0;
    tick();
    `CHK(flags, 4'h0)
    flagClr = 4'h2;
    pulse(4'hd);
    `CHK(flags, 4'h2)
    tick();
    flagClr = 4'h0;
    `CHK(flags, 4'h0)
    irqMask = 4'hf;
    globalDis = 1'b1;
    pulse(4'hb);
    repeat (4) tick();
    `CHK(ackN, 1'b1)
    `CHK(flags, 4'h4)
    nmiN = 1'b0;
    tick();
    nmiN = 1'b1;
    waitAck(NMI_VECTOR);
    globalDis = 1'b0;
    waitAck(IRQ_VECTOR_BASE + 16'h0008);
    pinReset();
    stop_test();
  end
endmodule
`default_nettype wire
